/* rsel_top.sv */
// module: instance selection, id multiplexing and partition parameter lookup
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - requests index parameters by partition id; flag 1 non-secure bank, 0 secure.
// - looked-up parameters leave with the request to govern its handling.
// - instance selection present; main feature id reports it set.
// - each partitioned or monitored resource owns a distinct selector value.
// - max instance field reads largest defined selector; gaps allowed below it.
// - monitors are reached by the same selector value in monitor select.
// - id registers carry no selector-to-resource mapping.
// - instance 0 fully identifiable and controllable with selector left at 0.
// - partition select's selector steers id reads and configuration accesses.
// - configuration accesses go to the held instance and partition.
// - component-wide control reachable only with selector 0.
// - with a single instance all controls sit at selector 0.
// - access to a missing control is bounded unpredictable behaviour.
// - id width, count and capture fields follow the selected instance.
// - main feature presence flags read 0 for features the instance lacks.
// - monitor feature flags report the selected instance's monitors, else 0.
// - priority id gives presence, width, polarity for both priority kinds.
// - component-wide priority id reads non-zero only at selector 0.
// - global id and select registers ignore the selector value.
// - no-impl flags tell if the impl id covers no monitors or partitioning.
// - undefined instance reads all presence flags 0, no error raised.
// - secure and non-secure select copies share a port, picked by ns.
module rsel_top import rsel_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // select register writes
    input wire rsel_sel_wr_t part_sel_wr_in,
    input wire rsel_sel_wr_t mon_sel_wr_in,
    // configuration and id accesses
    input wire rsel_cfg_t cfg_in,
    input wire rsel_id_rd_t id_rd_in,
    // incoming requests
    input wire rsel_req_t req_in,
    // select readback
    output rsel_sel_t part_sel_s_out,
    output rsel_sel_t part_sel_ns_out,
    output logic [INST_W-1:0] mon_sel_s_out,
    output logic [INST_W-1:0] mon_sel_ns_out,
    output logic [1:0] mon_sel_ok_out,
    // request parameters
    output logic req_valid_out,
    output logic req_ns_out,
    output logic [PART_W-1:0] req_part_out,
    output logic [NUM_INST-1:0][PARAM_W-1:0] req_ctrl_out,
    output logic [PARAM_W-1:0] req_pri_out,
    // access answers
    output logic cfg_rvalid_out,
    output logic [PARAM_W-1:0] cfg_rdata_out,
    output logic id_rvalid_out,
    output logic [DATA_W-1:0] id_rdata_out
);
    rsel_state_t st;
    rsel_state_t next_st;
    rsel_sel_t cfg_sel;
    rsel_sel_t id_sel;
    logic cfg_present;
    logic tbl_wr_ctrl;
    logic tbl_wr_pri;
    logic [PARAM_W-1:0] tbl_cfg_ctrl;
    logic [PARAM_W-1:0] tbl_cfg_pri;
    logic [NUM_INST-1:0][PARAM_W-1:0] tbl_req_ctrl;
    logic [PARAM_W-1:0] tbl_req_pri;

    // ----------------------------------------
    // capability helpers
    // ----------------------------------------
    // the full value is range checked; values above the maximum are undefined
    function automatic logic inst_defined(input logic [INST_W-1:0] i);
        return (i <= MAX_INSTANCE) && INST_DEFINED[i[IDX_W-1:0]];
    endfunction

    function automatic logic has(input logic [NUM_INST-1:0] m, input logic [INST_W-1:0] i);
        return inst_defined(i) && m[i[IDX_W-1:0]];
    endfunction

    function automatic logic [7:0] field(input logic [NUM_INST-1:0][7:0] t,
                                         input logic [INST_W-1:0] i);
        return inst_defined(i) ? t[i[IDX_W-1:0]] : 8'h00;
    endfunction

    // no mapping of selector to physical resource is encoded anywhere
    function automatic logic [DATA_W-1:0] id_value(input rsel_id_e idx,
                                                   input rsel_sel_t s);
        logic [DATA_W-1:0] r;
        logic [INST_W-1:0] i;
        r = ERR_ZERO;
        i = s.instance_selector;
        case (idx)
            ID_MAIN: begin
                r[MF_CAP] = has(INST_CAPACITY, i);
                r[MF_POR] = has(INST_PORTION, i);
                r[MF_BW] = 1'b0;
                r[MF_PRI] = (i == INST_ZERO);
                r[MF_IMPL] = has(INST_IMPL, i);
                r[MF_MON] = has(INST_BW_MON | INST_STOR_MON, i);
                r[MF_NO_PART] = !has(INST_IMPL, i);
                r[MF_NO_MON] = 1'b1;
                r[MF_HAS_SEL] = 1'b1;
                r[MF_MAX_LSB +: INST_W] = MAX_INSTANCE;
            end
            ID_CAPACITY: r[7:0] = has(INST_CAPACITY, i) ? field(CAP_WIDTH, i) : 8'h00;
            ID_PORTION: r[7:0] = has(INST_PORTION, i) ? field(PORTION_WIDTH, i) : 8'h00;
            ID_STOR_MON: begin
                r[7:0] = has(INST_STOR_MON, i) ? field(MON_COUNT, i) : 8'h00;
                r[CAPT_BIT] = has(INST_STOR_MON & INST_CAPTURE, i);
            end
            ID_MON_FEAT: begin
                r[MON_BW] = has(INST_BW_MON, i);
                r[MON_STOR] = has(INST_STOR_MON, i);
            end
            // priority acts on the whole component, so it shows at zero only
            ID_PRIORITY: r = (i == INST_ZERO) ? PRI_VALUE : ERR_ZERO;
            ID_BW_PART: r = ERR_ZERO;
            ID_BW_MON: begin
                r[7:0] = has(INST_BW_MON, i) ? field(MON_COUNT, i) : 8'h00;
                r[CAPT_BIT] = has(INST_BW_MON & INST_CAPTURE, i);
            end
            ID_IMPL: r = has(INST_IMPL, i) ? IMPL_VALUE : ERR_ZERO;
            ID_ARCH: r = ARCH_ID;
            ID_ERR_CTRL: r = ERR_ZERO;
            ID_ERR_STAT: r = ERR_ZERO;
            ID_IMPLEMENTER: r = IMPLEMENTER_ID;
            ID_NARROW: r = NARROW_ID;
            ID_SECURE: r = SECURE_ID;
            ID_PART_SEL: begin
                r[PART_W-1:0] = s.partition_id;
                r[PS_INST_LSB +: INST_W] = i;
            end
            default: r = ERR_ZERO;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // configuration decode
    // ----------------------------------------
    always_comb begin
        cfg_sel = cfg_in.ns ? st.sel_ns : st.sel_s;
        id_sel = id_rd_in.ns ? st.sel_ns : st.sel_s;
        if (cfg_in.index == CFG_COMMON_PRI) begin
            cfg_present = (cfg_sel.instance_selector == INST_ZERO);
        end else begin
            cfg_present = has(INST_PORTION | INST_CAPACITY, cfg_sel.instance_selector);
        end
        // writes to a missing control are dropped here
        tbl_wr_ctrl = cfg_in.valid && cfg_in.write && cfg_present
                      && (cfg_in.index == CFG_INST_CTRL);
        tbl_wr_pri = cfg_in.valid && cfg_in.write && cfg_present
                     && (cfg_in.index == CFG_COMMON_PRI);
    end

    rsel_param_table u_table (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_ctrl_in(tbl_wr_ctrl),
        .wr_pri_in(tbl_wr_pri),
        .wr_ns_in(cfg_in.ns),
        .wr_inst_in(cfg_sel.instance_selector[IDX_W-1:0]),
        .wr_part_in(cfg_sel.partition_id),
        .wr_data_in(cfg_in.wdata),
        .cfg_ns_in(cfg_in.ns),
        .cfg_inst_in(cfg_sel.instance_selector[IDX_W-1:0]),
        .cfg_part_in(cfg_sel.partition_id),
        .cfg_ctrl_out(tbl_cfg_ctrl),
        .cfg_pri_out(tbl_cfg_pri),
        .req_ns_in(req_in.security_space_flag),
        .req_part_in(req_in.partition_id),
        .req_ctrl_out(tbl_req_ctrl),
        .req_pri_out(tbl_req_pri)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        // selects change only on their own write
        if (part_sel_wr_in.valid) begin
            if (part_sel_wr_in.ns) begin
                next_st.sel_ns = part_sel_wr_in.sel;
            end else begin
                next_st.sel_s = part_sel_wr_in.sel;
            end
        end
        if (mon_sel_wr_in.valid) begin
            if (mon_sel_wr_in.ns) begin
                next_st.mon_ns = mon_sel_wr_in.sel.instance_selector;
            end else begin
                next_st.mon_s = mon_sel_wr_in.sel.instance_selector;
            end
        end
        next_st.mon_ok[0] = has(INST_BW_MON | INST_STOR_MON, next_st.mon_s);
        next_st.mon_ok[1] = has(INST_BW_MON | INST_STOR_MON, next_st.mon_ns);
        // request lookup, one cycle of latency
        next_st.req_valid = req_in.valid;
        if (req_in.valid) begin
            next_st.req_ns = req_in.security_space_flag;
            next_st.req_part = req_in.partition_id;
            next_st.req_ctrl = tbl_req_ctrl;
            next_st.req_pri = tbl_req_pri;
        end
        next_st.cfg_rvalid = cfg_in.valid && !cfg_in.write;
        if (cfg_in.valid && !cfg_in.write) begin
            if (!cfg_present) begin
                next_st.cfg_rdata = PARAM_RESET;
            end else if (cfg_in.index == CFG_COMMON_PRI) begin
                next_st.cfg_rdata = tbl_cfg_pri;
            end else begin
                next_st.cfg_rdata = tbl_cfg_ctrl;
            end
        end
        next_st.id_rvalid = id_rd_in.valid;
        if (id_rd_in.valid) begin
            // undefined selectors clear flags without any error side effect
            next_st.id_rdata = id_value(id_rd_in.index, id_sel);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign part_sel_s_out = st.sel_s;
    assign part_sel_ns_out = st.sel_ns;
    assign mon_sel_s_out = st.mon_s;
    assign mon_sel_ns_out = st.mon_ns;
    assign mon_sel_ok_out = st.mon_ok;
    assign req_valid_out = st.req_valid;
    assign req_ns_out = st.req_ns;
    assign req_part_out = st.req_part;
    assign req_ctrl_out = st.req_ctrl;
    assign req_pri_out = st.req_pri;
    assign cfg_rvalid_out = st.cfg_rvalid;
    assign cfg_rdata_out = st.cfg_rdata;
    assign id_rvalid_out = st.id_rvalid;
    assign id_rdata_out = st.id_rdata;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wr_present;
        cfg_in.valid && cfg_in.write && cfg_present && !part_sel_wr_in.valid;
    endsequence

    sequence s_rd_same;
        cfg_in.valid && !cfg_in.write && cfg_in.ns == $past(cfg_in.ns)
        && cfg_in.index == $past(cfg_in.index) && !part_sel_wr_in.valid;
    endsequence

    sequence s_cfg_read;
        cfg_in.valid && !cfg_in.write;
    endsequence

    sequence s_id_undef;
        id_rd_in.valid && !inst_defined(id_sel.instance_selector);
    endsequence

    chk_req_lookup: assert property (req_in.valid |=>
        req_valid_out && req_ns_out == $past(req_in.security_space_flag)
        && req_ctrl_out == $past(tbl_req_ctrl))
        else $error("request parameters not taken from its bank");

    chk_cfg_readback: assert property (s_wr_present ##1 s_rd_same |=>
        cfg_rvalid_out && cfg_rdata_out == $past(cfg_in.wdata, 2))
        else $error("configuration write not read back");

    chk_missing_zero: assert property (cfg_in.valid && !cfg_in.write && !cfg_present
        |=> cfg_rvalid_out && cfg_rdata_out == PARAM_RESET)
        else $error("missing control did not read zero");

    chk_undef_flags: assert property (id_rd_in.valid && id_rd_in.index == ID_MAIN
        && !inst_defined(id_sel.instance_selector)
        |=> (id_rdata_out & MF_FLAG_MASK) == ERR_ZERO)
        else $error("presence flags set for undefined instance");

    chk_has_select: assert property (id_rd_in.valid && id_rd_in.index == ID_MAIN
        |=> id_rdata_out[MF_HAS_SEL]
        && id_rdata_out[MF_MAX_LSB +: INST_W] == MAX_INSTANCE)
        else $error("select capability or maximum wrong");

    chk_pri_zero_only: assert property (id_rd_in.valid && id_rd_in.index == ID_PRIORITY
        && id_sel.instance_selector != INST_ZERO |=> id_rdata_out == ERR_ZERO)
        else $error("priority id non-zero away from instance zero");

    chk_global_fixed: assert property (id_rd_in.valid && id_rd_in.index == ID_ARCH
        |=> id_rvalid_out && id_rdata_out == ARCH_ID)
        else $error("global id changed with selector");

    chk_select_hold: assert property (!part_sel_wr_in.valid |=>
        $stable(part_sel_s_out) && $stable(part_sel_ns_out))
        else $error("select changed without a write");

    chk_common_inst0: assert property (cfg_in.valid && cfg_in.write
        && cfg_in.index == CFG_COMMON_PRI && cfg_sel.instance_selector != INST_ZERO
        |=> $stable(u_table.st.pri))
        else $error("common control written away from instance zero");

    chk_cfg_answer: assert property (s_cfg_read
        |=> cfg_rvalid_out)
        else $error("configuration read not answered");

    chk_cfg_quiet: assert property (!(cfg_in.valid && !cfg_in.write)
        |=> !cfg_rvalid_out && $stable(cfg_rdata_out))
        else $error("configuration answer without a read");

    chk_id_quiet: assert property (!id_rd_in.valid
        |=> !id_rvalid_out && $stable(id_rdata_out))
        else $error("id answer without a read");

    chk_req_quiet: assert property (!req_in.valid
        |=> !req_valid_out && $stable(req_ctrl_out) && $stable(req_pri_out))
        else $error("request answer without a request");

    chk_undef_fields: assert property ((s_id_undef ##0 (id_rd_in.index inside
        {ID_CAPACITY, ID_PORTION, ID_STOR_MON, ID_MON_FEAT, ID_BW_MON}))
        |=> id_rdata_out == ERR_ZERO)
        else $error("undefined instance reports capabilities");

    chk_missing_write: assert property (cfg_in.valid && cfg_in.write && !cfg_present
        |=> $stable(u_table.st))
        else $error("write to a missing control landed");

    chk_mon_defined: assert property (
        (mon_sel_ok_out[0] |-> inst_defined(mon_sel_s_out))
        and (mon_sel_ok_out[1] |-> inst_defined(mon_sel_ns_out)))
        else $error("monitor reported for undefined instance");

    chk_sel_write: assert property (part_sel_wr_in.valid && !part_sel_wr_in.ns
        |=> part_sel_s_out == $past(part_sel_wr_in.sel))
        else $error("secure select write not taken");
endmodule
`default_nettype wire

/* rsel_pkg.sv */
// package: constants, field layout and carrier types of the instance select block
package rsel_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int PART_W = 4;
    localparam int NUM_PART = 16;
    localparam int INST_W = 4;
    localparam int IDX_W = 2;
    localparam int NUM_INST = 4;
    localparam int PARAM_W = 8;
    localparam int DATA_W = 32;
    localparam logic [INST_W-1:0] MAX_INSTANCE = 4'h3;
    localparam logic [INST_W-1:0] INST_ZERO = 4'h0;
    // ----------------------------------------
    // per instance capabilities, bit n is instance n
    // ----------------------------------------
    // instance 2 is left unassigned inside the range
    localparam logic [NUM_INST-1:0] INST_DEFINED = 4'hB;
    localparam logic [NUM_INST-1:0] INST_PORTION = 4'h1;
    localparam logic [NUM_INST-1:0] INST_CAPACITY = 4'h2;
    localparam logic [NUM_INST-1:0] INST_BW_MON = 4'h8;
    localparam logic [NUM_INST-1:0] INST_STOR_MON = 4'h2;
    localparam logic [NUM_INST-1:0] INST_IMPL = 4'h1;
    localparam logic [NUM_INST-1:0] INST_CAPTURE = 4'h8;
    localparam logic [NUM_INST-1:0][7:0] PORTION_WIDTH = {8'h00, 8'h00, 8'h00, 8'h08};
    localparam logic [NUM_INST-1:0][7:0] CAP_WIDTH = {8'h00, 8'h00, 8'h07, 8'h00};
    localparam logic [NUM_INST-1:0][7:0] MON_COUNT = {8'h04, 8'h00, 8'h02, 8'h00};
    // ----------------------------------------
    // fixed id contents (identity values arbitrary)
    // ----------------------------------------
    localparam logic [DATA_W-1:0] IMPL_VALUE = 32'h0000_0001;
    localparam logic [DATA_W-1:0] ARCH_ID = 32'h0000_0011;
    localparam logic [DATA_W-1:0] IMPLEMENTER_ID = 32'h0000_0A5A;
    localparam logic [DATA_W-1:0] NARROW_ID = 32'h0000_000F;
    localparam logic [DATA_W-1:0] SECURE_ID = 32'h0000_000F;
    localparam logic [DATA_W-1:0] ERR_ZERO = 32'h0000_0000;
    // int present [0], polarity [1], width [9:4]; downstream at [16],[17],[25:20]
    localparam logic [DATA_W-1:0] PRI_VALUE = 32'h0031_0043;
    localparam logic [PARAM_W-1:0] PARAM_RESET = 8'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MF_CAP = 0;
    localparam int MF_POR = 1;
    localparam int MF_BW = 2;
    localparam int MF_PRI = 3;
    localparam int MF_IMPL = 4;
    localparam int MF_MON = 5;
    localparam int MF_NO_PART = 6;
    localparam int MF_NO_MON = 7;
    localparam int MF_HAS_SEL = 8;
    localparam int MF_MAX_LSB = 12;
    localparam int MON_BW = 0;
    localparam int MON_STOR = 1;
    localparam int CAPT_BIT = 31;
    localparam int PS_INST_LSB = 16;
    localparam logic [DATA_W-1:0] MF_FLAG_MASK = 32'h0000_003F;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ID_MAIN = 4'h0, ID_CAPACITY = 4'h1, ID_PORTION = 4'h2, ID_STOR_MON = 4'h3,
        ID_MON_FEAT = 4'h4, ID_PRIORITY = 4'h5, ID_BW_PART = 4'h6, ID_BW_MON = 4'h7,
        ID_IMPL = 4'h8, ID_ARCH = 4'h9, ID_ERR_CTRL = 4'hA, ID_ERR_STAT = 4'hB,
        ID_IMPLEMENTER = 4'hC, ID_NARROW = 4'hD, ID_SECURE = 4'hE, ID_PART_SEL = 4'hF
    } rsel_id_e;
    typedef enum logic {CFG_INST_CTRL = 1'h0, CFG_COMMON_PRI = 1'h1} rsel_cfg_e;
    typedef struct packed {
        logic [INST_W-1:0] instance_selector;
        logic [PART_W-1:0] partition_id;
    } rsel_sel_t;
    typedef struct packed {
        logic valid;
        logic security_space_flag;
        logic [PART_W-1:0] partition_id;
    } rsel_req_t;
    typedef struct packed {
        logic valid;
        logic ns;
        rsel_sel_t sel;
    } rsel_sel_wr_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic ns;
        rsel_cfg_e index;
        logic [PARAM_W-1:0] wdata;
    } rsel_cfg_t;
    typedef struct packed {
        logic valid;
        logic ns;
        rsel_id_e index;
    } rsel_id_rd_t;
    typedef struct packed {
        logic [1:0][NUM_INST-1:0][NUM_PART-1:0][PARAM_W-1:0] ctrl;
        logic [1:0][NUM_PART-1:0][PARAM_W-1:0] pri;
    } rsel_tbl_t;
    typedef struct packed {
        rsel_sel_t sel_s;
        rsel_sel_t sel_ns;
        logic [INST_W-1:0] mon_s;
        logic [INST_W-1:0] mon_ns;
        logic [1:0] mon_ok;
        logic req_valid;
        logic req_ns;
        logic [PART_W-1:0] req_part;
        logic [NUM_INST-1:0][PARAM_W-1:0] req_ctrl;
        logic [PARAM_W-1:0] req_pri;
        logic cfg_rvalid;
        logic [PARAM_W-1:0] cfg_rdata;
        logic id_rvalid;
        logic [DATA_W-1:0] id_rdata;
    } rsel_state_t;
endpackage

/* rsel_param_table.sv */
// module: secure and non-secure parameter arrays, controls per instance and partition, priority per partition
`timescale 1ns/10ps
`default_nettype none
module rsel_param_table import rsel_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write port
    input wire logic wr_ctrl_in,
    input wire logic wr_pri_in,
    input wire logic wr_ns_in,
    input wire logic [IDX_W-1:0] wr_inst_in,
    input wire logic [PART_W-1:0] wr_part_in,
    input wire logic [PARAM_W-1:0] wr_data_in,
    // configuration read port
    input wire logic cfg_ns_in,
    input wire logic [IDX_W-1:0] cfg_inst_in,
    input wire logic [PART_W-1:0] cfg_part_in,
    output logic [PARAM_W-1:0] cfg_ctrl_out,
    output logic [PARAM_W-1:0] cfg_pri_out,
    // request read port
    input wire logic req_ns_in,
    input wire logic [PART_W-1:0] req_part_in,
    output logic [NUM_INST-1:0][PARAM_W-1:0] req_ctrl_out,
    output logic [PARAM_W-1:0] req_pri_out
);
    rsel_tbl_t st;
    rsel_tbl_t next_st;

    // ----------------------------------------
    // update
    // ----------------------------------------
    always_comb begin
        next_st = st;
        if (wr_ctrl_in) begin
            next_st.ctrl[wr_ns_in][wr_inst_in][wr_part_in] = wr_data_in;
        end
        if (wr_pri_in) begin
            next_st.pri[wr_ns_in][wr_part_in] = wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= {($bits(rsel_tbl_t) / PARAM_W){PARAM_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // reads
    // ----------------------------------------
    assign cfg_ctrl_out = st.ctrl[cfg_ns_in][cfg_inst_in][cfg_part_in];
    assign cfg_pri_out = st.pri[cfg_ns_in][cfg_part_in];
    assign req_pri_out = st.pri[req_ns_in][req_part_in];

    // every instance looks up the same partition in the bank the flag names
    for (genvar g = 0; g < NUM_INST; g++) begin : g_req
        assign req_ctrl_out[g] = st.ctrl[req_ns_in][g][req_part_in];
    end
endmodule
`default_nettype wire

/* rsel_requester.sv */
// requester model driving partition-tagged requests into the block
`timescale 1ns/10ps
`default_nettype none
module rsel_requester import rsel_pkg::*; (
    // clock
    input wire logic clk_in,
    // request out
    output var rsel_req_t req_out
);
    // falling edge launch keeps the request clear of the sampling edge
    task automatic issue(input logic flag, input logic [PART_W-1:0] part);
        @(negedge clk_in);
        req_out = {1'b1, flag, part};
        @(negedge clk_in);
        req_out.valid = 1'b0;
        // released lines do not keep the last id
        req_out.partition_id = ~part;
    endtask
    initial req_out = '0;
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking testbench of the instance select block
`timescale 1ns/10ps
`default_nettype none
module testbench import rsel_pkg::*;;
    logic clk_in, rst_n_in, rq_v, rq_ns, cf_v, id_v;
    rsel_sel_wr_t ps_wr, ms_wr;
    rsel_cfg_t cfg;
    rsel_id_rd_t idr;
    rsel_req_t req;
    rsel_sel_t ps_s, ps_ns;
    logic [INST_W-1:0] ms_s, ms_ns;
    logic [1:0] ms_ok;
    logic [PART_W-1:0] rq_part;
    logic [NUM_INST-1:0][PARAM_W-1:0] rq_ctrl;
    logic [PARAM_W-1:0] rq_pri, cf_d;
    logic [DATA_W-1:0] id_d;
    int n_fail, num_checks;
    rsel_requester req_model (.clk_in(clk_in), .req_out(req));
    rsel_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .part_sel_wr_in(ps_wr),
        .mon_sel_wr_in(ms_wr), .cfg_in(cfg), .id_rd_in(idr), .req_in(req),
        .part_sel_s_out(ps_s), .part_sel_ns_out(ps_ns), .mon_sel_s_out(ms_s),
        .mon_sel_ns_out(ms_ns), .mon_sel_ok_out(ms_ok), .req_valid_out(rq_v),
        .req_ns_out(rq_ns), .req_part_out(rq_part), .req_ctrl_out(rq_ctrl),
        .req_pri_out(rq_pri), .cfg_rvalid_out(cf_v), .cfg_rdata_out(cf_d),
        .id_rvalid_out(id_v), .id_rdata_out(id_d));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // bounded wait; a hang ends the run
    task automatic wait_hi(ref logic flag);
        int k;
        for (k = 0; k < 4 && flag !== 1'b1; k++) @(negedge clk_in);
        if (k == 4) begin
            n_fail++;
            close_out();
        end
    endtask
    task automatic sel(input logic mon, input logic ns, input logic [3:0] inst, part);
        @(negedge clk_in);
        if (mon) ms_wr = {1'b1, ns, inst, part};
        else ps_wr = {1'b1, ns, inst, part};
        @(negedge clk_in);
        ms_wr.valid = 1'b0;
        ps_wr.valid = 1'b0;
    endtask
    task automatic cfg_acc(input logic wr, ns, rsel_cfg_e idx, input logic [7:0] wd, exp);
        @(negedge clk_in);
        cfg = {1'b1, wr, ns, idx, wd};
        @(negedge clk_in);
        cfg.valid = 1'b0;
        if (!wr) begin
            wait_hi(cf_v);
            check(cf_d, exp);
        end
    endtask
    task automatic id_read(input rsel_id_e idx, input logic ns = 1'b0);
        @(negedge clk_in);
        idr = {1'b1, ns, idx};
        @(negedge clk_in);
        idr.valid = 1'b0;
        wait_hi(id_v);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_ids;
        logic [7:0] flags [4] = '{8'h9A, 8'hE1, 8'hC0, 8'hE0};
        for (int i = 0; i < NUM_INST; i++) begin
            sel(1'b0, 1'b0, INST_W'(i), 4'h0);
            id_read(ID_MAIN);
            check({id_d[15:12], id_d[8], id_d[7:0]}, {MAX_INSTANCE, 1'b1, flags[i]});
            id_read(ID_PRIORITY);
            check(id_d, (i == 0) ? PRI_VALUE : 32'h0000_0000);
            id_read(ID_ARCH);
            check(id_d, ARCH_ID);
            id_read(ID_PORTION);
            check(id_d[7:0], PORTION_WIDTH[i]);
            id_read(ID_CAPACITY);
            check(id_d[7:0], CAP_WIDTH[i]);
            id_read(ID_MON_FEAT);
            check(id_d[1:0], {INST_STOR_MON[i], INST_BW_MON[i]});
            id_read(ID_STOR_MON);
            check(id_d, (i == 1) ? 32'h0000_0002 : 32'h0000_0000);
            id_read(ID_BW_MON);
            check(id_d, (i == 3) ? 32'h8000_0004 : 32'h0000_0000);
        end
    endtask
    task automatic t_cfg;
        sel(1'b0, 1'b0, 4'h0, 4'h5);
        sel(1'b0, 1'b1, 4'h0, 4'h5);
        // write and read back on adjacent edges
        @(negedge clk_in);
        cfg = {1'b1, 1'b1, 1'b1, CFG_INST_CTRL, 8'hC3};
        @(negedge clk_in);
        cfg.write = 1'b0;
        @(negedge clk_in);
        cfg.valid = 1'b0;
        wait_hi(cf_v);
        check(cf_d, 8'hC3);
        cfg_acc(1'b1, 1'b0, CFG_INST_CTRL, 8'hA5, 8'h00);
        cfg_acc(1'b1, 1'b1, CFG_INST_CTRL, 8'h5A, 8'h00);
        cfg_acc(1'b1, 1'b0, CFG_COMMON_PRI, 8'h77, 8'h00);
        cfg_acc(1'b0, 1'b0, CFG_INST_CTRL, 8'h00, 8'hA5);
        cfg_acc(1'b0, 1'b1, CFG_INST_CTRL, 8'h00, 8'h5A);
        cfg_acc(1'b0, 1'b0, CFG_COMMON_PRI, 8'h00, 8'h77);
        sel(1'b0, 1'b0, 4'h2, 4'h5);
        cfg_acc(1'b1, 1'b0, CFG_INST_CTRL, 8'h3C, 8'h00);
        cfg_acc(1'b1, 1'b0, CFG_COMMON_PRI, 8'h11, 8'h00);
        cfg_acc(1'b0, 1'b0, CFG_INST_CTRL, 8'h00, 8'h00);
        cfg_acc(1'b0, 1'b0, CFG_COMMON_PRI, 8'h00, 8'h00);
        // a truncating decode would alias 8 onto instance 0
        sel(1'b0, 1'b0, 4'h8, 4'h5);
        cfg_acc(1'b1, 1'b0, CFG_INST_CTRL, 8'h99, 8'h00);
        cfg_acc(1'b0, 1'b0, CFG_INST_CTRL, 8'h00, 8'h00);
        check({ps_s, ps_ns}, {4'h8, 4'h5, 4'h0, 4'h5});
        id_read(ID_PART_SEL);
        check(id_d, 32'h0008_0005);
        id_read(ID_MAIN, 1'b1);
        check(id_d[7:0], 8'h9A);
    endtask
    task automatic t_req;
        req_model.issue(1'b0, 4'h5);
        wait_hi(rq_v);
        check({rq_ns, rq_part, rq_ctrl[0], rq_pri}, {1'b0, 4'h5, 8'hA5, 8'h77});
        check(rq_ctrl, {8'h00, 8'h00, 8'h00, 8'hA5});
        req_model.issue(1'b1, 4'h5);
        wait_hi(rq_v);
        check({rq_ns, rq_ctrl[0], rq_pri}, {1'b1, 8'h5A, 8'h00});
        req_model.issue(1'b1, 4'h6);
        wait_hi(rq_v);
        check({rq_part, rq_ctrl[0]}, {4'h6, 8'h00});
    endtask
    task automatic t_mon;
        sel(1'b1, 1'b0, 4'h1, 4'h0);
        check({ms_s, ms_ok[0]}, {4'h1, 1'b1});
        sel(1'b1, 1'b1, 4'h2, 4'h0);
        check({ms_ns, ms_ok[1]}, {4'h2, 1'b0});
        sel(1'b1, 1'b1, 4'h3, 4'h0);
        check({ms_ns, ms_ok[1]}, {4'h3, 1'b1});
    endtask
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        {ps_wr, ms_wr, cfg, idr} = '0;
        rst_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        t_ids();
        t_cfg();
        t_req();
        t_mon();
        close_out();
    end
endmodule
`default_nettype wire
